// ### dv/timer_two_counter_core_test.sv
/*
 * Self-checking bench for the second timer's counting core.
 * Assumes the design files and the event source model are compiled first.
 */
`default_nettype none
module timer_two_counter_core_test;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Signals and instances
    // ****************************************
    logic              clk = 1'b0;
    logic              rst_b = 1'b0;
    logic [7:0]        wdata = 8'h00;
    logic [4:0]        wr = 5'h00;
    logic [7:0]        q1, q2, qp, qc, qt;
    logic [1:0]        edge_sel = 2'h0;
    tmc_pkg::tmc_evt_t evt_in = '0;
    tmc_pkg::tmc_out_t evt_out;
    logic [15:0]       count;
    logic              ovf, irq, pin, busy;
    logic              src_go = 1'b0;
    logic [4:0]        src_n = 5'h00;
    logic [15:0]       v;
    int                bad_count = 0;
    int                cmp_count = 0;
    int                seed = 8;
    int                irq_n, t, k;
    always #5 clk = ~clk;
    tmc_timer_two_core DUT (.CORE_CLK(clk), .RST_B(rst_b), .WDATA(wdata), .TIMER_CTRL_FIRST_WR(wr[0]),
        .TIMER_CTRL_SECOND_WR(wr[1]), .PRM_WR(wr[2]), .CRC_WR(wr[3]), .TOC_WR(wr[4]), .TIMER_CTRL_FIRST_Q(q1),
        .TIMER_CTRL_SECOND_Q(q2), .PRM_Q(qp), .CRC_Q(qc), .TOC_Q(qt), .EVENT_COUNT_INPUT(pin),
        .EDGE_SEL(edge_sel), .EVT_IN(evt_in), .COUNT(count), .OVF_PULSE(ovf),
        .EXT_IRQ_PULSE(irq), .EVT_OUT(evt_out));
    tmc_evt_src src (.clk(clk), .start(src_go), .toggles(src_n), .pin(pin), .busy(busy));
    // ****************************************
    // Helpers
    // ****************************************
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Strobe lasts one cycle; the result is looked at a cycle and a half after it lands
    task automatic wr_reg(input int idx, input logic [7:0] d);
        @(posedge clk);
        wdata <= d;
        wr <= 5'(5'h01 << idx);
        @(posedge clk);
        wr <= 5'h00;
        repeat (2) @(negedge clk);
    endtask
    // Bounded waits: a run-out counts as a mismatch and ends the run
    task automatic wait_cnt(input logic [15:0] val, input bit chg);
        for (int i = 0; i < 4000; i++) begin
            @(negedge clk);
            if ((count === val) != chg) return;
        end
        bad_count++;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, count, val);
        stop_test();
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(negedge clk);
        chk(count, 16'h0000);
        chk({q1, q2}, {tmc_pkg::TIMER_CTRL_FIRST_RESET, tmc_pkg::TIMER_CTRL_SECOND_RESET});
        chk({qp, qc}, {tmc_pkg::PRM_RESET, tmc_pkg::CRC_RESET});
        chk(16'(qt), 16'h0000);
        v = 16'($random(seed));
        wr_reg(4, v[7:0]);
        chk(16'(qt), 16'(v[7:0]));
        repeat (9) @(negedge clk);
        chk(count, 16'h0000);
        $display("test reset done");
        // Tick every cycle; a written overflow bit must not stick
        wr_reg(2, 8'h00);
        wr_reg(0, 8'h48);
        chk(16'(q1), 16'h0008);
        v = count;
        @(negedge clk);
        chk(count, v + 16'h0001);
        v = count;
        wr_reg(0, 8'h08);
        chk(count, v + 16'h0003);
        @(posedge clk);
        evt_in.hit_a <= 1'b1;
        repeat (2) @(negedge clk);
        chk(16'(evt_out.match_a), 16'h0001);
        wr_reg(0, 8'h00);
        chk(count, 16'h0000);
        chk(16'(evt_out.match_a), 16'h0000);
        @(posedge clk);
        evt_in <= '0;
        $display("test run done");
        // Wrap at 0xff in 8 bits, no wrap at 0xff in 16 bits; the restart after the stop begins from zero
        wr_reg(0, 8'h08);
        chk(count, 16'h0000);
        @(negedge clk);
        chk(count, 16'h0001);
        wait_cnt(16'h00ff, 1'b0);
        @(negedge clk);
        chk({count[14:0], ovf}, 16'h0001);
        repeat (40) @(negedge clk);
        chk(16'(q1), 16'h0048);
        wr_reg(0, 8'h00);
        chk(16'(q1), 16'h0000);
        wr_reg(1, 8'h01);
        wr_reg(0, 8'h08);
        wait_cnt(16'h00ff, 1'b0);
        @(negedge clk);
        chk({count[14:0], ovf}, 16'h0200);
        wr_reg(0, 8'h00);
        wr_reg(1, 8'h00);
        $display("test wrap done");
        // Capture clear on c, match clear, no clear, capture clear on b; tick every 4 cycles
        wr_reg(2, 8'h20);
        for (k = 0; k < 4; k++) begin
            wr_reg(3, k == 0 ? 8'h30 : (k == 1 ? 8'h18 : (k == 2 ? 8'h10 : 8'h1c)));
            wr_reg(0, 8'h08);
            t = 3 + ($random(seed) & 7);
            wait_cnt(16'(t), 1'b0);
            @(posedge clk);
            evt_in.hit_b <= (k == 1);
            evt_in.trig_b <= (k == 3);
            evt_in.trig_c <= (k == 0 || k == 2);
            @(posedge clk);
            evt_in <= '0;
            @(negedge clk);
            chk(16'(evt_out), 16'(k == 1 ? 4'h4 : (k == 3 ? 4'h2 : 4'h1)));
            wait_cnt(16'(t), 1'b1);
            chk(count, k == 1 ? 16'h0000 : 16'(t + 1));
            @(negedge clk);
            chk(count, k == 2 ? 16'(t + 1) : 16'h0000);
            wr_reg(0, 8'h00);
        end
        $display("test clear done");
        // Event counting on rising, falling and both edges
        wr_reg(2, 8'h70);
        for (k = 0; k < 3; k++) begin
            @(posedge clk);
            edge_sel <= 2'(k);
            t = 2 * (1 + ($random(seed) & 3));
            wr_reg(0, 8'h08);
            @(posedge clk);
            src_n <= 5'(t);
            src_go <= 1'b1;
            @(posedge clk);
            src_go <= 1'b0;
            irq_n = 0;
            for (int i = 0; i < 120; i++) begin
                @(negedge clk);
                if (irq === 1'b1) irq_n++;
            end
            chk(16'(irq_n), 16'(k == 2 ? t : t / 2));
            chk(count, 16'(k == 2 ? t - 1 : t / 2 - 1));
            wr_reg(0, 8'h00);
        end
        $display("test event done");
        stop_test();
    end
endmodule
`default_nettype wire

// ### dv/tmc_evt_src.sv
/*
 * Event pulse source standing on the counter input pin.
 * Assumes the bench pulses start for one cycle while busy is low.
 */
`default_nettype none
module tmc_evt_src (
    // Clock
    input  wire logic       clk,
    // Request
    input  wire logic       start,
    input  wire logic [4:0] toggles,
    // Pin side
    output logic            pin,
    output logic            busy
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Toggle engine
    // ****************************************
    logic [4:0] left;
    logic [2:0] hold;
    initial begin
        pin = 1'b0;
        busy = 1'b0;
        left = 5'h00;
        hold = 3'h0;
    end
    // Each level stands 4 clocks, a period of 8: the fastest pin the core must count
    always @(posedge clk) begin
        if (start) begin
            busy <= 1'b1;
            left <= toggles;
            hold <= 3'h0;
        end else if (busy && hold != 3'h3) begin
            hold <= hold + 3'h1;
        end else if (busy) begin
            pin <= ~pin;
            hold <= 3'h0;
            left <= left - 5'h01;
            busy <= (left != 5'h01);
        end
    end
endmodule
`default_nettype wire

// ### hdl/tmc_pkg.sv
/*
 * Constants and carrier types for the second timer's counting core.
 * Assumes a single system clock; every user of these names writes tmc_pkg::name.
 */
`default_nettype none
package tmc_pkg;
    // ****************************************
    // Register fields and reset values
    // ****************************************
    localparam int unsigned RUN_BIT_POS    = 3;      // Run bit inside timer_ctrl_first
    localparam int unsigned OVF_BIT_POS    = 6;      // Overflow flag inside timer_ctrl_first
    localparam int unsigned WIDTH_SEL_POS  = 0;      // Width select inside timer_ctrl_second
    localparam int unsigned CMP_CAP_POS    = 2;      // Register b acts as capture when set
    localparam int unsigned CLR_MATCH_POS  = 3;      // clear_on_match_enable
    localparam int unsigned CLR_CAPT_POS   = 5;      // clear_on_capture_enable
    localparam logic [7:0]  TIMER_CTRL_FIRST_RESET     = 8'h00;
    localparam logic [7:0]  TIMER_CTRL_SECOND_RESET     = 8'h00;
    localparam logic [7:0]  PRM_RESET      = 8'h11;
    localparam logic [7:0]  CRC_RESET      = 8'h10;
    localparam logic [7:0]  TOC_RESET      = 8'h00;
    // ****************************************
    // Count clock selection
    // ****************************************
    localparam logic [3:0]  PRESC_EXT      = 4'h7;   // Count clock from event_count_input
    localparam int unsigned PRESC_W        = 8;      // Free-running prescaler width
    localparam int unsigned CNT_W          = 16;
    localparam logic [15:0] MAX_NARROW     = 16'h00ff;
    localparam logic [15:0] MAX_WIDE       = 16'hffff;
    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic hit_a;     // Count equals compare_reg_a
        logic hit_b;     // Count equals compare_capture_reg_b
        logic trig_b;    // Valid capture edge for register b
        logic trig_c;    // Valid capture edge for capture_reg_c
    } tmc_evt_t;
    typedef struct packed {
        logic match_a;
        logic match_b;
        logic capt_b;
        logic capt_c;
    } tmc_out_t;
endpackage
`default_nettype wire

// ### hdl/tmc_timer_two_core.sv
/*
 * Counting core of the second timer: prescaled or external-event count clock,
 * run control, overflow wrap, automatic clear after match or capture.
 * Assumes compare/capture datapaths and waveform logic sit outside and talk to
 * this core through the event and strobe ports; register writes arrive as
 * one-cycle strobes on CORE_CLK.
 */
// Operation
// [RULE_01] Width select bit 0 of second control register picks 8 or 16 bits.
// [RULE_02] Counter adds one per count clock chosen by prescaler upper nibble.
// [RULE_03] Run bit 3 enables counting; first count clock after set loads zero.
// [RULE_04] Clearing run zeroes counter at once and stops capture and match output.
// [RULE_05] Writing one to an already set run bit changes nothing.
// [RULE_06] Count clock at all-ones wraps to zero, sets flag, pulses overflow.
// [RULE_07] Overflow flag is set by hardware and cleared only by software.
// [RULE_08] Reset zeroes the counter and stops counting.
// [RULE_09] Enabled clear source holds value; counter becomes zero on next count clock.
// [RULE_10] Restart after stop counts from zero on first count clock after set.
// [RULE_11] Selecting the event pin as count clock makes an event counter.
// [RULE_12] Event source holds each level at least 4 system clocks.
// [RULE_13] Event counting works up to one eighth of the system clock.
// [RULE_14] Capture clear briefly shows N+1 before zero, so compare may hit.
// [RULE_15] Event pin also raises its external interrupt while counting.
// [RULE_16] Output control register resets to zero; upper nibble drives this timer.
// [RULE_17] Capture/compare control picks match clear, capture clear, both or none.
// [RULE_18] Count clock is a one-cycle enable in the system clock domain.
`default_nettype none
module tmc_timer_two_core (
    // Clock and reset
    input  wire logic              CORE_CLK,
    input  wire logic              RST_B,
    // Register writes
    input  wire logic [7:0]        WDATA,
    input  wire logic              TIMER_CTRL_FIRST_WR,
    input  wire logic              TIMER_CTRL_SECOND_WR,
    input  wire logic              PRM_WR,
    input  wire logic              CRC_WR,
    input  wire logic              TOC_WR,
    // Register contents
    output logic [7:0]             TIMER_CTRL_FIRST_Q,
    output logic [7:0]             TIMER_CTRL_SECOND_Q,
    output logic [7:0]             PRM_Q,
    output logic [7:0]             CRC_Q,
    output logic [7:0]             TOC_Q,
    // Event pin and its edge choice
    input  wire logic              EVENT_COUNT_INPUT,
    input  wire logic [1:0]        EDGE_SEL,
    // Compare and capture events from the datapath
    input  wire tmc_pkg::tmc_evt_t EVT_IN,
    // Results
    output logic [15:0]            COUNT,
    output logic                   OVF_PULSE,
    output logic                   EXT_IRQ_PULSE,
    output tmc_pkg::tmc_out_t      EVT_OUT
);
    // ****************************************
    // Reset release
    // ****************************************
    logic rst_meta_reg;
    logic rst_sync_reg;
    // Release is synchronised so no flop leaves reset on a different edge
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    wire logic rst_n = rst_sync_reg;

    // ****************************************
    // Event pin synchroniser and edge detect
    // ****************************************
    logic ev_meta_reg;
    logic ev_sync_reg;
    logic ev_prev_reg;
    logic ev_edge;
    // Pin passes two flops; the second and its one-cycle delayed copy feed the edge logic
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            ev_meta_reg <= 1'b0;
            ev_sync_reg <= 1'b0;
            ev_prev_reg <= 1'b0;
        end else begin
            ev_meta_reg <= EVENT_COUNT_INPUT;
            ev_sync_reg <= ev_meta_reg;
            ev_prev_reg <= ev_sync_reg;
        end
    end
    // Levels held 4 clocks survive the 2-flop delay; faster pulses may vanish
    always_comb begin
        case (EDGE_SEL)
            2'h0:    ev_edge = ev_sync_reg & ~ev_prev_reg;
            2'h1:    ev_edge = ~ev_sync_reg & ev_prev_reg;
            default: ev_edge = ev_sync_reg ^ ev_prev_reg;
        endcase
    end // RULE_12 RULE_13

    // ****************************************
    // State and next values
    // ****************************************
    logic [7:0]                 timer_ctrl_first_reg, timer_ctrl_first_next;
    logic [7:0]                 timer_ctrl_second_reg, timer_ctrl_second_next;
    logic [7:0]                 prm_reg, prm_next;
    logic [7:0]                 crc_reg, crc_next;
    logic [7:0]                 toc_reg, toc_next;
    logic [tmc_pkg::PRESC_W-1:0] presc_reg, presc_next;
    logic [tmc_pkg::CNT_W-1:0]  count_reg, count_next;
    logic                       start_pend_reg, start_pend_next;
    logic                       clr_pend_reg, clr_pend_next;
    logic                       clr_capt_reg, clr_capt_next;
    logic                       glitch_reg, glitch_next;
    logic                       ovf_pulse_reg, ovf_pulse_next;
    logic                       irq_reg, irq_next;
    tmc_pkg::tmc_out_t          out_reg, out_next;

    logic                       run;
    logic                       wide;
    logic [3:0]                 sel;
    logic [tmc_pkg::PRESC_W-1:0] mask;
    logic                       presc_tick;
    logic                       tick;
    logic [tmc_pkg::CNT_W-1:0]  max_val;
    logic                       clr_match;
    logic                       clr_capt;

    // Decode of control fields and the single-cycle count enable
    always_comb begin
        run        = timer_ctrl_first_reg[tmc_pkg::RUN_BIT_POS];
        wide       = timer_ctrl_second_reg[tmc_pkg::WIDTH_SEL_POS];                 // RULE_01
        sel        = prm_reg[7:4];                                     // RULE_02
        mask       = tmc_pkg::PRESC_W'((9'h001 << sel[2:0]) - 9'h001);
        presc_tick = ((presc_reg & mask) == mask);
        // External selection needs no mode bit of its own
        tick       = run & ((sel == tmc_pkg::PRESC_EXT) ? ev_edge : presc_tick); // RULE_11 RULE_18
        max_val    = wide ? tmc_pkg::MAX_WIDE : tmc_pkg::MAX_NARROW;
        // Register b clears on match when compare, on capture when capturing
        clr_match  = crc_reg[tmc_pkg::CLR_MATCH_POS] & ~crc_reg[tmc_pkg::CMP_CAP_POS] & EVT_IN.hit_b;
        clr_capt   = (crc_reg[tmc_pkg::CLR_MATCH_POS] & crc_reg[tmc_pkg::CMP_CAP_POS] & EVT_IN.trig_b)
                   | (crc_reg[tmc_pkg::CLR_CAPT_POS] & EVT_IN.trig_c);  // RULE_17
    end

    // Next values of the registers and the counter
    always_comb begin
        timer_ctrl_first_next       = timer_ctrl_first_reg;
        timer_ctrl_second_next       = TIMER_CTRL_SECOND_WR ? WDATA : timer_ctrl_second_reg;
        prm_next        = PRM_WR ? WDATA : prm_reg;
        crc_next        = CRC_WR ? WDATA : crc_reg;
        toc_next        = TOC_WR ? WDATA : toc_reg;                    // RULE_16
        presc_next      = presc_reg + 1'b1;
        count_next      = count_reg;
        start_pend_next = start_pend_reg;
        clr_pend_next   = clr_pend_reg;
        clr_capt_next   = clr_capt_reg;
        glitch_next     = 1'b0;
        ovf_pulse_next  = 1'b0;
        // Counter logic, run bit taken before this cycle's write
        if (glitch_reg) begin
            count_next = '0;                                           // RULE_14
        end else if (tick) begin
            if (start_pend_reg) begin
                count_next      = '0;                                  // RULE_03 RULE_10
                start_pend_next = 1'b0;
            end else if (clr_pend_reg || clr_match) begin
                // A match level still seen on the tick is the same match
                clr_pend_next = 1'b0;
                if (clr_pend_reg && clr_capt_reg) begin
                    count_next  = (count_reg + 1'b1) & max_val;        // RULE_14
                    glitch_next = 1'b1;
                end else begin
                    count_next  = '0;                                  // RULE_09
                end
            end else if (count_reg == max_val) begin
                count_next     = '0;                                   // RULE_06
                ovf_pulse_next = 1'b1;
            end else begin
                count_next = count_reg + 1'b1;                         // RULE_02
            end
        end
        // Clear sources wait for the next count clock; a match level on the
        // clearing tick was consumed above and must not arm a second clear
        if (run && clr_capt) begin
            clr_pend_next = 1'b1;                                      // RULE_09
            clr_capt_next = 1'b1;
        end else if (run && clr_match && !tick) begin
            clr_pend_next = 1'b1;                                      // RULE_09 RULE_17
            if (!clr_pend_reg) begin
                clr_capt_next = 1'b0;
            end
        end
        // Software write; a hardware overflow in the same cycle still lands
        if (TIMER_CTRL_FIRST_WR) begin
            timer_ctrl_first_next = WDATA;
            timer_ctrl_first_next[tmc_pkg::OVF_BIT_POS] = timer_ctrl_first_reg[tmc_pkg::OVF_BIT_POS]
                                            & WDATA[tmc_pkg::OVF_BIT_POS]; // RULE_07
            if (!WDATA[tmc_pkg::RUN_BIT_POS]) begin
                count_next      = '0;                                  // RULE_04
                start_pend_next = 1'b0;
                clr_pend_next   = 1'b0;
                glitch_next     = 1'b0;
            end else if (!run) begin
                start_pend_next = 1'b1;                                // RULE_03 RULE_05
            end
        end
        if (ovf_pulse_next) begin
            timer_ctrl_first_next[tmc_pkg::OVF_BIT_POS] = 1'b1;                    // RULE_06 RULE_07
        end
        // Match and capture strobes only while running
        out_next.match_a = run & EVT_IN.hit_a;                         // RULE_04
        out_next.match_b = run & EVT_IN.hit_b & ~crc_reg[tmc_pkg::CMP_CAP_POS];
        out_next.capt_b  = run & EVT_IN.trig_b & crc_reg[tmc_pkg::CMP_CAP_POS];
        out_next.capt_c  = run & EVT_IN.trig_c;
        // Interrupt function of the event pin stays live in every mode
        irq_next = ev_edge;                                            // RULE_15
    end

    // Registering stage only
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            timer_ctrl_first_reg       <= tmc_pkg::TIMER_CTRL_FIRST_RESET;                     // RULE_08
            timer_ctrl_second_reg       <= tmc_pkg::TIMER_CTRL_SECOND_RESET;
            prm_reg        <= tmc_pkg::PRM_RESET;
            crc_reg        <= tmc_pkg::CRC_RESET;
            toc_reg        <= tmc_pkg::TOC_RESET;                      // RULE_16
            presc_reg      <= '0;
            count_reg      <= '0;                                      // RULE_08
            start_pend_reg <= 1'b0;
            clr_pend_reg   <= 1'b0;
            clr_capt_reg   <= 1'b0;
            glitch_reg     <= 1'b0;
            ovf_pulse_reg  <= 1'b0;
            irq_reg        <= 1'b0;
            out_reg        <= '0;
        end else begin
            timer_ctrl_first_reg       <= timer_ctrl_first_next;
            timer_ctrl_second_reg       <= timer_ctrl_second_next;
            prm_reg        <= prm_next;
            crc_reg        <= crc_next;
            toc_reg        <= toc_next;
            presc_reg      <= presc_next;
            count_reg      <= count_next;
            start_pend_reg <= start_pend_next;
            clr_pend_reg   <= clr_pend_next;
            clr_capt_reg   <= clr_capt_next;
            glitch_reg     <= glitch_next;
            ovf_pulse_reg  <= ovf_pulse_next;
            irq_reg        <= irq_next;
            out_reg        <= out_next;
        end
    end

    // Outputs straight from flops
    assign TIMER_CTRL_FIRST_Q        = timer_ctrl_first_reg;
    assign TIMER_CTRL_SECOND_Q        = timer_ctrl_second_reg;
    assign PRM_Q         = prm_reg;
    assign CRC_Q         = crc_reg;
    assign TOC_Q         = toc_reg;
    assign COUNT         = count_reg;
    assign OVF_PULSE     = ovf_pulse_reg;
    assign EXT_IRQ_PULSE = irq_reg;
    assign EVT_OUT       = out_reg;

    // ****************************************
    // Checks
    // ****************************************
    chk_stop_zeroes: assert property (@(posedge CORE_CLK) disable iff (!rst_n) // RULE_04
        (TIMER_CTRL_FIRST_WR && !WDATA[tmc_pkg::RUN_BIT_POS]) |=> (COUNT == '0))
        else $error("Counter not zero after run cleared");
    chk_start_load: assert property (@(posedge CORE_CLK) disable iff (!rst_n) // RULE_03
        (tick && start_pend_reg && !TIMER_CTRL_FIRST_WR) |=> (COUNT == '0) && !start_pend_reg)
        else $error("First count clock did not load zero");
    chk_rerun_none: assert property (@(posedge CORE_CLK) disable iff (!rst_n) // RULE_05
        (TIMER_CTRL_FIRST_WR && WDATA[tmc_pkg::RUN_BIT_POS] && run && !start_pend_reg) |=> !start_pend_reg)
        else $error("Rewrite of run restarted the count");
    chk_wrap_flag: assert property (@(posedge CORE_CLK) disable iff (!rst_n) // RULE_06
        (tick && !glitch_reg && !start_pend_reg && !clr_pend_reg && !clr_match && COUNT == max_val && !TIMER_CTRL_FIRST_WR)
        |=> (COUNT == '0) && OVF_PULSE && TIMER_CTRL_FIRST_Q[tmc_pkg::OVF_BIT_POS])
        else $error("Wrap did not set overflow");
    chk_ovf_sticky: assert property (@(posedge CORE_CLK) disable iff (!rst_n) // RULE_07
        ($rose(TIMER_CTRL_FIRST_Q[tmc_pkg::OVF_BIT_POS]) |-> $past(ovf_pulse_next))
        and ($fell(TIMER_CTRL_FIRST_Q[tmc_pkg::OVF_BIT_POS]) |-> $past(TIMER_CTRL_FIRST_WR)))
        else $error("Overflow flag moved without cause");
    chk_clear_wait: assert property (@(posedge CORE_CLK) disable iff (!rst_n) // RULE_09
        (clr_pend_reg && !tick && !glitch_reg && !TIMER_CTRL_FIRST_WR) |=> $stable(COUNT))
        else $error("Counter changed before next count clock");
    chk_capt_glitch: assert property (@(posedge CORE_CLK) disable iff (!rst_n) // RULE_14
        (glitch_reg && !TIMER_CTRL_FIRST_WR) |-> (COUNT != '0) ##1 (COUNT == '0))
        else $error("Capture clear glitch sequence wrong");
    chk_narrow_width: assert property (@(posedge CORE_CLK) disable iff (!rst_n) // RULE_01
        (!wide && COUNT[15:8] == 8'h00 && !TIMER_CTRL_FIRST_WR) |=> (COUNT[15:8] == 8'h00))
        else $error("Narrow mode counter left eight bits");
    chk_strobe_gate: assert property (@(posedge CORE_CLK) disable iff (!rst_n) // RULE_04
        !run |=> (EVT_OUT == '0))
        else $error("Match or capture strobe while stopped");
    chk_match_clear: assert property (@(posedge CORE_CLK) disable iff (!rst_n) // RULE_09
        (tick && clr_match && !glitch_reg && !start_pend_reg && !clr_pend_reg && !TIMER_CTRL_FIRST_WR) |=> (COUNT == '0))
        else $error("Match clear did not zero the counter");
    chk_no_clear: assert property (@(posedge CORE_CLK) disable iff (!rst_n) // RULE_17
        (tick && !crc_reg[tmc_pkg::CLR_MATCH_POS] && !crc_reg[tmc_pkg::CLR_CAPT_POS] && !glitch_reg
         && !start_pend_reg && !clr_pend_reg && !TIMER_CTRL_FIRST_WR && COUNT != max_val)
        |=> (COUNT == $past(COUNT) + 16'h0001))
        else $error("Counter skipped a step with clearing disabled");
endmodule
`default_nettype wire
